/* File: src/lps_slave.sv */
`timescale 1ns/1ps
module lps_slave
    import lps_pkg::*;
#(
    parameter int FILT_CYC = SPIKE_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Address strap
    input wire logic addr_strap_pin,
    // Two-wire link
    lps_i2c_if.dev link,
    // Received bytes towards the storage logic
    output logic [7:0] wr_data,
    output logic cmd_stb,
    output logic ram_stb,
    output logic pwm_stb,
    // Access status
    output logic acc_end,
    output logic addressed
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (FILT_CYC < 1 || FILT_CYC > QTR_CYC / 2) begin : g_bad_filt
        $error("lps_slave: FILT_CYC out of range");
    end

    // ------------------------------------------------------------
    // Line conditioning
    // ------------------------------------------------------------
    logic scl_f;
    logic sda_f;
    logic strap_f;

    // Both lines and the strap pass the same sync and spike filter
    lps_filt #(.N(FILT_CYC), .RST_VAL(LINE_IDLE)) u_scl_filt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin_in(link.scl),
        .level(scl_f)
    );

    lps_filt #(.N(FILT_CYC), .RST_VAL(LINE_IDLE)) u_sda_filt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin_in(link.sda),
        .level(sda_f)
    );

    lps_filt #(.N(FILT_CYC), .RST_VAL(1'b0)) u_strap_filt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin_in(addr_strap_pin),
        .level(strap_f)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    lps_slv_st_e st_q;
    lps_slv_st_e st_d;
    logic scl_p_q;
    logic sda_p_q;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic ack_ph_q;
    logic ack_ph_d;
    logic drive_q;
    logic drive_d;
    logic more_q;
    logic more_d;
    logic [1:0] tsel_q;
    logic [1:0] tsel_d;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic cmd_q;
    logic cmd_d;
    logic ram_q;
    logic ram_d;
    logic pwm_q;
    logic pwm_d;
    logic end_q;
    logic end_d;

    // ------------------------------------------------------------
    // Edge and condition decode
    // ------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_end;
    logic ack_end;
    logic addr_hit;
    logic in_access;

    assign scl_rise = scl_f && !scl_p_q;
    assign scl_fall = !scl_f && scl_p_q;
    // Data moving while the clock stays high is a condition, not a bit
    assign start_det = scl_f && scl_p_q && sda_p_q && !sda_f;
    assign stop_det = scl_f && scl_p_q && !sda_p_q && sda_f;
    // Eighth bit done once the clock falls; the ninth slot follows
    assign byte_end = scl_fall && (bit_q == BYTE_BITS) && !ack_ph_q;
    assign ack_end = scl_fall && ack_ph_q;
    // Write-only receiver: a read direction is never acknowledged
    assign addr_hit = (shift_q[7:2] == ADDR_HI)
                      && (shift_q[1] == strap_f)
                      && (shift_q[0] == ADDR_WR);
    assign in_access = (st_q == ST_CTRL) || (st_q == ST_DATA);

    // ------------------------------------------------------------
    // Receive sequencer
    // ------------------------------------------------------------
    // START and STOP are honoured in every state, so a stray byte or a
    // foreign transfer can never lock the receiver out
    always_comb begin
        st_d = st_q;
        shift_d = shift_q;
        bit_d = bit_q;
        ack_ph_d = ack_ph_q;
        drive_d = drive_q;
        more_d = more_q;
        tsel_d = tsel_q;
        data_d = data_q;
        cmd_d = 1'b0;
        ram_d = 1'b0;
        pwm_d = 1'b0;
        end_d = 1'b0;
        if (start_det) begin
            st_d = ST_ADDR;
            bit_d = 4'h0;
            ack_ph_d = 1'b0;
            drive_d = 1'b0;
            end_d = in_access;
        end else if (stop_det) begin
            st_d = ST_IDLE;
            bit_d = 4'h0;
            ack_ph_d = 1'b0;
            drive_d = 1'b0;
            end_d = in_access;
        end else if (st_q != ST_IDLE) begin
            if (scl_rise && bit_q != BYTE_BITS) begin
                shift_d = {shift_q[6:0], sda_f};
                bit_d = bit_q + 4'h1;
            end
            if (byte_end) begin
                ack_ph_d = 1'b1;
                unique case (st_q)
                    ST_ADDR: begin
                        if (addr_hit) begin
                            drive_d = 1'b1;
                            st_d = ST_CTRL;
                        end else begin
                            st_d = ST_SKIP;
                        end
                    end
                    ST_CTRL: begin
                        drive_d = 1'b1;
                        more_d = shift_q[CTRL_MORE_BIT];
                        tsel_d = shift_q[TSEL_HI:TSEL_LO];
                        st_d = ST_DATA;
                    end
                    ST_DATA: begin
                        drive_d = 1'b1;
                        data_d = shift_q;
                        cmd_d = (tsel_q == TSEL_CMD);
                        ram_d = (tsel_q == TSEL_RAM);
                        pwm_d = (tsel_q == TSEL_PWM);
                        // Chained mode returns to control after one byte
                        if (more_q) begin
                            st_d = ST_CTRL;
                        end
                    end
                    ST_SKIP, ST_IDLE: begin
                    end
                endcase
            end
            // Release after the ninth clock falls: held over its high
            if (ack_end) begin
                ack_ph_d = 1'b0;
                drive_d = 1'b0;
                bit_d = 4'h0;
            end
        end
    end

    // Unused target: no strobe fires, byte is still acknowledged
    // (TSEL_NONE falls through every compare above)

    // ------------------------------------------------------------
    // State flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
            scl_p_q <= LINE_IDLE;
            sda_p_q <= LINE_IDLE;
            shift_q <= 8'h00;
            bit_q <= 4'h0;
            ack_ph_q <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            st_q <= st_d;
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
            shift_q <= shift_d;
            bit_q <= bit_d;
            ack_ph_q <= ack_ph_d;
            drive_q <= drive_d;
        end
    end

    // Selected target and output strobes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            more_q <= 1'b0;
            tsel_q <= TSEL_NONE;
            data_q <= 8'h00;
            cmd_q <= 1'b0;
            ram_q <= 1'b0;
            pwm_q <= 1'b0;
            end_q <= 1'b0;
        end else begin
            more_q <= more_d;
            tsel_q <= tsel_d;
            data_q <= data_d;
            cmd_q <= cmd_d;
            ram_q <= ram_d;
            pwm_q <= pwm_d;
            end_q <= end_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Only ever pulls low: the device never drives a START itself
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = drive_q;
    assign wr_data = data_q;
    assign cmd_stb = cmd_q;
    assign ram_stb = ram_q;
    assign pwm_stb = pwm_q;
    assign acc_end = end_q;
    assign addressed = in_access;

endmodule // lps_slave

/* File: shared/lps_pkg.sv */
package lps_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    // System clock period in ns (40 MHz)
    localparam int SYS_CLK_NS = 25;
    // Shortest line level that counts as real, in ns
    localparam int SPIKE_NS = 50;
    // Stable cycles needed before a filtered line follows, rounded up
    localparam int SPIKE_CYC = (SPIKE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    // Link clock period that the host generates, in ns (400 kHz)
    localparam int SCL_PERIOD_NS = 2500;
    // Quarter of a link clock period in system cycles, rounded down
    localparam int QTR_CYC = SCL_PERIOD_NS / (4 * SYS_CLK_NS);

    // ------------------------------------------------------------
    // Byte framing
    // ------------------------------------------------------------
    // Bits in a byte; the count value that marks the acknowledge slot
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // Fixed upper part of the slave address, bits 7 to 2
    localparam logic [5:0] ADDR_HI = 6'h1C;
    // Direction bit value for a write
    localparam logic ADDR_WR = 1'b0;
    // Idle level of both lines and of the line filters after reset
    localparam logic LINE_IDLE = 1'b1;

    // ------------------------------------------------------------
    // Control byte layout
    // ------------------------------------------------------------
    localparam int CTRL_MORE_BIT = 7;
    localparam int TSEL_HI = 6;
    localparam int TSEL_LO = 5;

    // Target select codes
    localparam logic [1:0] TSEL_CMD = 2'h0;
    localparam logic [1:0] TSEL_RAM = 2'h1;
    localparam logic [1:0] TSEL_PWM = 2'h2;
    localparam logic [1:0] TSEL_NONE = 2'h3;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CTRL, ST_DATA, ST_SKIP
    } lps_slv_st_e;

    typedef enum logic [1:0] {
        M_IDLE, M_START, M_BITS, M_STOP
    } lps_mst_st_e;

endpackage

/* File: shared/lps_i2c_if.sv */
`timescale 1ns/1ps
interface lps_i2c_if;

    // Resolved wire levels, pulled up when nobody drives
    logic scl;
    logic sda;
    // Host drive of both lines
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    // Device drive of the data line
    logic dev_sda_o;
    logic dev_sda_oe;

    // Wired-AND: a driven low wins, otherwise the pull-up
    assign scl = (host_scl_oe && !host_scl_o) ? 1'b0 : 1'b1;
    assign sda = ((host_sda_oe && !host_sda_o)
                  || (dev_sda_oe && !dev_sda_o)) ? 1'b0 : 1'b1;

    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input scl, input sda, output host_scl_o,
                  output host_scl_oe, output host_sda_o,
                  output host_sda_oe);

endinterface

/* File: src/lps_filt.sv */
`timescale 1ns/1ps
module lps_filt #(
    parameter int N = 2,
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Raw line and filtered level
    input wire logic pin_in,
    output logic level
);

    localparam int CW = $clog2(N + 1);

    if (N < 1) begin : g_bad_n
        $error("lps_filt: N must be at least 1");
    end

    logic sync1_q;
    logic sync2_q;
    logic level_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic differ;
    logic settle;

    // The level follows only after N stable cycles, so spikes are dropped
    assign differ = sync2_q != level_q;
    assign settle = differ && (cnt_q == CW'(N - 1));
    assign cnt_d = (differ && !settle) ? CW'(cnt_q + 1'b1) : '0;
    assign level = level_q;

    // Two-stage synchroniser, then the stability counter
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= RST_VAL;
            sync2_q <= RST_VAL;
            level_q <= RST_VAL;
            cnt_q <= '0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            cnt_q <= cnt_d;
            if (settle) begin
                level_q <= sync2_q;
            end
        end
    end

endmodule // lps_filt

/* File: src/lps_master.sv */
`timescale 1ns/1ps
module lps_master
    import lps_pkg::*;
#(
    parameter int QTR = QTR_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Two-wire link
    lps_i2c_if.host link,
    // Access request
    input wire logic go,
    input wire logic addr_sel,
    // Data bytes to send
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic byte_last,
    output logic byte_ready,
    // Status
    output logic busy,
    output logic done,
    output logic nack
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    localparam int QW = $clog2(QTR);

    if (QTR < 4 * SPIKE_CYC) begin : g_bad_qtr
        $error("lps_master: QTR too short for the slave filter");
    end

    // ------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------
    logic scl_f;
    logic sda_f;

    lps_filt #(.N(SPIKE_CYC), .RST_VAL(LINE_IDLE)) u_scl_filt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin_in(link.scl),
        .level(scl_f)
    );

    lps_filt #(.N(SPIKE_CYC), .RST_VAL(LINE_IDLE)) u_sda_filt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin_in(link.sda),
        .level(sda_f)
    );

    // ------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------
    lps_mst_st_e st_q;
    logic [QW-1:0] q_cnt_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic last_q;
    logic nack_q;
    logic done_q;
    logic tick;
    logic ack_slot;
    logic bus_idle;
    logic take_go;

    assign tick = q_cnt_q == QW'(QTR - 1);
    assign ack_slot = bit_q == BYTE_BITS;
    // A transfer begins only with both lines seen high
    assign bus_idle = scl_f && sda_f;
    assign take_go = (st_q == M_IDLE) && go && bus_idle;
    // Next byte is fetched at the end of each acknowledged slot, except after the last byte
    assign byte_ready = (st_q == M_BITS) && tick && (ph_q == 2'h3)
                        && ack_slot && !nack_q && !last_q;

    // ------------------------------------------------------------
    // Quarter-period divider
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q_cnt_q <= '0;
        end else if (st_q == M_IDLE || tick) begin
            q_cnt_q <= '0;
        end else begin
            q_cnt_q <= q_cnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Bit sequencer
    // ------------------------------------------------------------
    // Each bit is four quarters: set data, raise, sample, lower
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= M_IDLE;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            last_q <= 1'b0;
            nack_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (st_q)
                M_IDLE: begin
                    if (take_go) begin
                        sda_oe_q <= 1'b1;
                        shift_q <= {ADDR_HI, addr_sel, ADDR_WR};
                        bit_q <= 4'h0;
                        nack_q <= 1'b0;
                        last_q <= 1'b0;
                        st_q <= M_START;
                    end
                end
                M_START: begin
                    if (tick) begin
                        scl_oe_q <= 1'b1;
                        ph_q <= 2'h0;
                        st_q <= M_BITS;
                    end
                end
                M_BITS: begin
                    if (tick) begin
                        unique case (ph_q)
                            2'h0: sda_oe_q <= !ack_slot && !shift_q[7];
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: if (ack_slot) nack_q <= sda_f;
                            2'h3: scl_oe_q <= 1'b1;
                        endcase
                        if (ph_q != 2'h3) begin
                            ph_q <= ph_q + 2'h1;
                        end else if (!ack_slot) begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            bit_q <= bit_q + 4'h1;
                            ph_q <= 2'h0;
                        end else if (nack_q || last_q) begin
                            ph_q <= 2'h0;
                            st_q <= M_STOP;
                        end else if (byte_valid) begin
                            shift_q <= byte_data;
                            last_q <= byte_last;
                            bit_q <= 4'h0;
                            ph_q <= 2'h0;
                        end
                    end
                end
                M_STOP: begin
                    if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        unique case (ph_q)
                            2'h0: sda_oe_q <= 1'b1;
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b0;
                            2'h3: begin
                                done_q <= 1'b1;
                                st_q <= M_IDLE;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open-drain: the lines are only ever pulled low
    assign link.host_scl_o = 1'b0;
    assign link.host_scl_oe = scl_oe_q;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = sda_oe_q;
    assign busy = st_q != M_IDLE;
    assign done = done_q;
    assign nack = nack_q;

endmodule // lps_master

/* File: dv/lps_properties.sv */
`timescale 1ns/1ps
module lps_properties (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Link wires and drives
    input wire logic scl,
    input wire logic sda,
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe
);
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic start_w;
    logic rise_w;

    // Clock rises since START; wraps after the ninth so ack slot is 9
    assign start_w = scl && scl_q && sda_q && !sda;
    assign rise_w = scl && !scl_q;
    assign cnt_d = start_w ? 4'h0 : !rise_w ? cnt_q :
                   (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;

    // Wire history, idle high after reset like the pull-ups
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            cnt_q <= 4'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_ack_stable;
        scl && $past(scl) |-> $stable(dev_sda_oe);
    endproperty
    a_ack_stable: assert property (p_ack_stable)
        else $error("device data drive moved while clock high");
    property p_start_clk;
        $rose(host_sda_oe) && scl |-> ##[1:300] !scl;
    endproperty
    a_start_clk: assert property (p_start_clk)
        else $error("no clock fall after start");
    property p_open_drain;
        dev_sda_oe |-> !dev_sda_o && !sda;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("device drive does not pull data low");
    property p_ack_hold;
        dev_sda_oe && $rose(scl) |-> dev_sda_oe until !scl;
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("ack dropped during clock high");
    property p_ack_rel;
        $fell(scl) && cnt_q == 4'h9 && dev_sda_oe |-> ##[1:20] !dev_sda_oe;
    endproperty
    a_ack_rel: assert property (p_ack_rel)
        else $error("ack not released after ninth clock");
    property p_stop;
        $fell(host_sda_oe) && scl |-> sda && !dev_sda_oe;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop blocked by device drive");
    property p_ack_cnt;
        $rose(dev_sda_oe) |-> cnt_q == 4'h8 && !scl;
    endproperty
    a_ack_cnt: assert property (p_ack_cnt)
        else $error("ack not after eighth bit");
    property p_host_rel;
        scl && $past(scl) && cnt_q == 4'h9 |-> !host_sda_oe;
    endproperty
    a_host_rel: assert property (p_host_rel)
        else $error("host drives data in ack slot");
endmodule // lps_properties

/* File: dv/lcd_pwm_i2c_slave_rx_bench.sv */
`timescale 1ns/1ps
module lcd_pwm_i2c_slave_rx_bench
    import lps_pkg::*;
;
    logic sys_clk, nrst, strap, go, addr_sel, byte_valid, byte_last;
    logic [7:0] byte_data, wr_data, wr_data2;
    logic byte_ready, busy, done, nack, cmd_stb, ram_stb, pwm_stb;
    logic acc_end, addressed, cmd2, ram2, pwm2, end2, adr2;
    logic [9:0] got_q[$];
    logic [9:0] exp_q[$];
    logic [7:0] tx[$];
    logic [8:0] wire_sh;
    int fail_count, num_checks, cyc, bitn, ends, ends2, stb2, adr_seen2;

    // ------------------------------------------------------------
    // Two ends on one link, a lone device on a bench-driven link
    // ------------------------------------------------------------
    lps_i2c_if link();
    lps_i2c_if link2();
    lps_master #(.QTR(10)) lps_master_inst (.sys_clk, .nrst,
        .link(link.host), .go, .addr_sel, .byte_valid, .byte_data,
        .byte_last, .byte_ready, .busy, .done(done), .nack);
    lps_slave lps_slave_inst (.sys_clk, .nrst, .addr_strap_pin(strap),
        .link(link.dev), .wr_data, .cmd_stb, .ram_stb, .pwm_stb,
        .acc_end, .addressed);
    lps_slave lps_slave_bb_inst (.sys_clk, .nrst, .addr_strap_pin(strap),
        .link(link2.dev), .wr_data(wr_data2), .cmd_stb(cmd2),
        .ram_stb(ram2), .pwm_stb(pwm2), .acc_end(end2), .addressed(adr2));
    lps_properties lps_properties_inst (.sys_clk, .nrst, .scl(link.scl),
        .sda(link.sda), .host_scl_oe(link.host_scl_oe),
        .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
        .dev_sda_oe(link.dev_sda_oe));

    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Strobe log, pulse counts and hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cmd_stb === 1'b1) got_q.push_back({TSEL_CMD, wr_data});
        if (ram_stb === 1'b1) got_q.push_back({TSEL_RAM, wr_data});
        if (pwm_stb === 1'b1) got_q.push_back({TSEL_PWM, wr_data});
        if (acc_end === 1'b1) ends++;
        if ((cmd2 | ram2 | pwm2) === 1'b1) stb2++;
        if (end2 === 1'b1) ends2++;
        if (adr2 === 1'b1) adr_seen2++;
        if (cyc == 60000) begin
            fail_count++;
            wrap_up();
        end
    end

    // Wire view: first nine bits after START, MSB first
    always @(negedge link.sda) if (link.scl === 1'b1) bitn = 0;
    always @(posedge link.scl) begin
        if (bitn < 9) wire_sh = {wire_sh[7:0], link.sda};
        bitn++;
    end

    task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task cmp_q;
        chk("stb_count", 10'(exp_q.size()), 10'(got_q.size()));
        foreach (exp_q[k]) if (k < got_q.size()) chk("stb", exp_q[k], got_q[k]);
    endtask

    // One access; the host may stop early on a refused address
    task run_acc(input logic sel);
        int i;
        i = 0;
        got_q.delete();
        ends = 0;
        @(negedge sys_clk);
        addr_sel = sel;
        go = 1'b1;
        byte_valid = 1'b1;
        byte_data = tx[0];
        byte_last = (tx.size() == 1);
        while (busy !== 1'b1) @(negedge sys_clk);
        go = 1'b0;
        while (busy === 1'b1) begin
            @(negedge sys_clk);
            if (byte_ready === 1'b1) begin
                @(negedge sys_clk);
                i++;
                if (i < tx.size()) begin
                    byte_data = tx[i];
                    byte_last = (i == tx.size() - 1);
                end
            end
        end
        chk("done", 10'h1, 10'(done));
        byte_valid = 1'b0;
        repeat (20) @(negedge sys_clk);
    endtask

    // Chained control bytes, every target code, data that looks like control
    task t_mixed;
        tx = '{8'h80, 8'h11, 8'hC0, 8'h22, 8'hE0, 8'h33, 8'h20, 8'h80, 8'h55};
        exp_q = '{{TSEL_CMD, 8'h11}, {TSEL_PWM, 8'h22},
                  {TSEL_RAM, 8'h80}, {TSEL_RAM, 8'h55}};
        run_acc(1'b1);
        cmp_q();
        chk("nack", 10'h0, 10'(nack));
        chk("acc_end", 10'h1, 10'(ends));
        chk("addr_wire", {ADDR_HI, 1'b1, ADDR_WR, 1'b0}, 10'(wire_sh));
        chk("idle", 10'h3, {8'h0, link.scl, link.sda});
    endtask

    // Strap mismatch: no ack, nothing delivered
    task t_mismatch;
        tx = '{8'h40, 8'h66};
        exp_q.delete();
        run_acc(1'b0);
        cmp_q();
        chk("nack", 10'h1, 10'(nack));
        chk("acc_end", 10'h0, 10'(ends));
        chk("addr_wire", {ADDR_HI, 1'b0, ADDR_WR, 1'b1}, 10'(wire_sh));
    endtask

    // Strap low selects the other address
    task t_strap0;
        strap = 1'b0;
        repeat (20) @(negedge sys_clk);
        tx = '{8'h40, 8'h5A};
        exp_q = '{{TSEL_PWM, 8'h5A}};
        run_acc(1'b0);
        cmp_q();
        chk("nack", 10'h0, 10'(nack));
    endtask

    task bb(input logic s, input logic c, input int n = 8);
        link2.host_sda_oe = !s;
        link2.host_scl_oe = !c;
        repeat (n) @(negedge sys_clk);
    endtask

    task bb_byte(input logic [7:0] b, input int n);
        for (int k = 7; k > 7 - n; k--) begin
            bb(b[k], 1'b0, 3);
            bb(b[k], 1'b1, 2);
            bb(b[k], 1'b0, 3);
        end
    endtask

    task bb_ack;
        bb(1'b1, 1'b0, 3);
        bb(1'b1, 1'b1, 2);
        chk("ack_wire", 10'h0, 10'(link2.sda));
        bb(1'b1, 1'b0, 3);
    endtask

    // Master aborts with STOP in mid-byte: partial byte is dropped
    task t_abort;
        bb(1'b1, 1'b1);
        bb(1'b0, 1'b1);
        bb(1'b0, 1'b0);
        bb_byte({ADDR_HI, 1'b0, ADDR_WR}, 8);
        bb_ack();
        bb_byte(8'h20, 8);
        bb_ack();
        bb_byte(8'hA5, 3);
        bb(1'b0, 1'b0);
        bb(1'b0, 1'b1);
        bb(1'b1, 1'b1);
        repeat (20) @(negedge sys_clk);
        chk("addressed", 10'h1, 10'(adr_seen2 > 0));
        chk("acc_end", 10'h1, 10'(ends2));
        chk("stb", 10'h0, 10'(stb2));
        chk("addressed_end", 10'h0, 10'(adr2));
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Reset, then scenarios
    initial begin
        {nrst, go, addr_sel, byte_valid, byte_last} = 5'h0;
        byte_data = 8'h00;
        strap = 1'b1;
        {fail_count, num_checks, cyc, ends, ends2, stb2, adr_seen2} = '0;
        bitn = 9;
        wire_sh = 9'h000;
        {link2.host_scl_o, link2.host_sda_o} = 2'h0;
        {link2.host_scl_oe, link2.host_sda_oe} = 2'h0;
        repeat (4) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (10) @(negedge sys_clk);
        t_mixed();
        t_mismatch();
        t_strap0();
        t_abort();
        wrap_up();
    end
endmodule // lcd_pwm_i2c_slave_rx_bench
